//--- design/scg_pkg.sv
// Constants and types for the cell-search sync channel generator
package scg_pkg;
	localparam int CHIPS_PER_CODE     = 256;
	localparam int CHIP_IDX_W         = 8;
	localparam int SLOTS_PER_FRAME    = 15;
	localparam int SLOT_IDX_W         = 4;
	localparam int NUM_SSC_CODES      = 16;
	localparam int SSC_IDX_W          = 4;
	localparam int NUM_CODE_GROUPS    = 32;
	localparam int GROUP_W            = 5;
	localparam int CODES_PER_GROUP    = 16;
	localparam int BUF_DEPTH          = 2;
	// Seed of the fixed primary code; value is arbitrary
	localparam logic [15:0] PSC_SEED  = 16'hA5C3;
	localparam logic [7:0]  LAST_CHIP = 8'hFF;
	localparam logic [3:0]  LAST_SLOT = 4'hE;
	localparam logic [3:0]  FIRST_SLOT = 4'h0;
	// Chip bit: 0 stands for +1, 1 for -1
	localparam logic CHIP_PLUS = 1'b0;

	typedef enum logic [0:0]
	{
		SCG_IDLE  = 1'b0,
		SCG_BURST = 1'b1
	} scg_state_e;

	typedef struct packed
	{
		logic                  ant_sel;
		logic                  psc_chip;
		logic                  ssc_chip;
		logic [SLOT_IDX_W-1:0] slot_idx;
		logic [CHIP_IDX_W-1:0] chip_idx;
	} scg_word_s;
endpackage

//--- design/scg_stream_if.sv
// Valid/ready carrier for generated chip words
`timescale 1ns/1ns
interface scg_stream_if;
	import scg_pkg::*;
	scg_word_s data;
	logic      valid;
	logic      ready;

	modport src
	(
		output data,
		output valid,
		input  ready
	);
	modport snk
	(
		input  data,
		input  valid,
		output ready
	);
endinterface

//--- design/scg_buffer.sv
// Two-entry chip buffer with registered head
`timescale 1ns/1ns
module scg_buffer
(
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	scg_stream_if.snk         in_s,
	output scg_pkg::scg_word_s out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	import scg_pkg::*;

	scg_word_s tail_r;
	logic      tail_valid_r;
	logic      push;
	logic      pop;

	// Head always sits in out_data_o so the output needs no mux
	assign in_s.ready = !tail_valid_r;
	assign push       = in_s.valid && !tail_valid_r;
	assign pop        = out_valid_o && out_ready_i;

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			out_valid_o  <= 1'b0;
			tail_valid_r <= 1'b0;
		end
		else if (pop)
		begin
			out_valid_o  <= tail_valid_r || push;
			tail_valid_r <= tail_valid_r && push;
		end
		else if (push)
		begin
			out_valid_o  <= 1'b1;
			tail_valid_r <= out_valid_o;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			out_data_o <= '0;
			tail_r     <= '0;
		end
		else if (pop)
		begin
			out_data_o <= tail_valid_r ? tail_r : in_s.data;
			if (push)
				tail_r <= in_s.data;
		end
		else if (push)
		begin
			if (out_valid_o)
				tail_r <= in_s.data;
			else
				out_data_o <= in_s.data;
		end
	end
endmodule

//--- design/scg_top.sv
// Downlink cell-search sync channel generator
`timescale 1ns/1ns
module scg_top
#(
	parameter int CHIPS = scg_pkg::CHIPS_PER_CODE
)
(
	input  wire logic                       clk_sys_i,
	input  wire logic                       reset_i,
	input  wire logic                       slot_strobe_i,
	input  wire logic                       frame_strobe_i,
	input  wire logic [scg_pkg::GROUP_W-1:0] code_group_i,
	input  wire logic                       space_time_tx_diversity_i,
	input  wire logic                       time_switched_tx_diversity_i,
	input  wire logic                       out_ready_i,
	output logic                            out_valid_o,
	output logic                            ant0_en_o,
	output logic                            ant1_en_o,
	output logic                            psc_chip_o,
	output logic                            ssc_chip_o,
	output logic [scg_pkg::SLOT_IDX_W-1:0]  slot_idx_o,
	output logic [scg_pkg::CHIP_IDX_W-1:0]  chip_idx_o,
	output logic                            busy_o
);
	import scg_pkg::*;

	if (CHIPS != CHIPS_PER_CODE)
	begin
		$error("scg_top: code length must be 256 chips");
	end

	scg_state_e            state_r;
	logic [CHIP_IDX_W-1:0] chip_r;
	logic [SLOT_IDX_W-1:0] slot_r;
	logic [SLOT_IDX_W-1:0] slot_nxt;
	logic [SSC_IDX_W-1:0]  ssc_sel_r;
	logic                  sign_neg_r;
	logic                  ant_r;
	logic                  gen_take;
	scg_word_s             head;
	scg_stream_if          gen_s ();

	// Code index from group and slot; 32 distinct 15-entry sequences
	function automatic logic [SSC_IDX_W-1:0] ssc_select
	(
		input logic [GROUP_W-1:0]    grp,
		input logic [SLOT_IDX_W-1:0] slot
	);
		logic [SLOT_IDX_W:0] step;
		step = {1'b0, slot} << grp[4];
		ssc_select = grp[3:0] + step[SSC_IDX_W-1:0];
	endfunction

	// Hierarchical code built from one constant seed only
	function automatic logic psc_bit(input logic [CHIP_IDX_W-1:0] n);
		psc_bit = PSC_SEED[n[3:0]] ^ PSC_SEED[n[7:4]];
	endfunction

	// Walsh-masked variant of the primary: 16 distinct codes
	function automatic logic ssc_bit
	(
		input logic [SSC_IDX_W-1:0]  k,
		input logic [CHIP_IDX_W-1:0] n
	);
		ssc_bit = (^(k & n[7:4])) ^ PSC_SEED[n[3:0]];
	endfunction

	assign slot_nxt = (frame_strobe_i || slot_r == LAST_SLOT) ?
		FIRST_SLOT : slot_r + 4'h1;
	assign gen_take = gen_s.valid && gen_s.ready;

	// Late slot strobe restarts the burst; a stalled sink never drops
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			state_r <= SCG_IDLE;
			chip_r  <= '0;
		end
		else if (slot_strobe_i)
		begin
			state_r <= SCG_BURST;
			chip_r  <= '0;
		end
		else if (gen_take)
		begin
			chip_r <= chip_r + 8'h01;
			if (chip_r == LAST_CHIP)
				state_r <= SCG_IDLE;
		end
	end

	// Slot index resets to the last slot so a bare strobe starts at 0
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			slot_r <= LAST_SLOT;
		else if (slot_strobe_i)
			slot_r <= slot_nxt;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			ssc_sel_r  <= '0;
			sign_neg_r <= 1'b1;
		end
		else if (slot_strobe_i)
		begin
			ssc_sel_r  <= ssc_select(code_group_i, slot_nxt);
			sign_neg_r <= !space_time_tx_diversity_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			ant_r <= 1'b0;
		else if (slot_strobe_i)
		begin
			if (!time_switched_tx_diversity_i || frame_strobe_i)
				ant_r <= 1'b0;
			else
				ant_r <= !ant_r;
		end
	end

	assign gen_s.valid         = (state_r == SCG_BURST) && !slot_strobe_i;
	// Whole word in one assignment: the carrier holds a single variable
	assign gen_s.data = '{
		ant_sel:  ant_r,
		psc_chip: psc_bit(chip_r) ^ sign_neg_r,
		ssc_chip: ssc_bit(ssc_sel_r, chip_r) ^ sign_neg_r,
		slot_idx: slot_r,
		chip_idx: chip_r
	};

	scg_buffer u_buffer
	(
		.clk_sys_i   (clk_sys_i),
		.reset_i     (reset_i),
		.in_s        (gen_s.snk),
		.out_data_o  (head),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i)
	);

	// Antenna enables registered so outputs come from flops
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			ant0_en_o <= 1'b0;
			ant1_en_o <= 1'b0;
			busy_o    <= 1'b0;
		end
		else
		begin
			ant0_en_o <= (state_r == SCG_BURST) && !ant_r;
			ant1_en_o <= (state_r == SCG_BURST) && ant_r;
			busy_o    <= (state_r == SCG_BURST);
		end
	end

	assign psc_chip_o = head.psc_chip;
	assign ssc_chip_o = head.ssc_chip;
	assign slot_idx_o = head.slot_idx;
	assign chip_idx_o = head.chip_idx;
endmodule

//--- sim/scg_properties.sv
// Port properties of the sync channel generator
`timescale 1ns/1ns
module scg_properties
(
	input wire logic       clk_sys_i,
	input wire logic       reset_i,
	input wire logic       slot_strobe_i,
	input wire logic       space_time_tx_diversity_i,
	input wire logic       out_ready_i,
	input wire logic       out_valid_o,
	input wire logic       ant0_en_o,
	input wire logic       ant1_en_o,
	input wire logic       psc_chip_o,
	input wire logic [3:0] slot_idx_o,
	input wire logic [7:0] chip_idx_o,
	input wire logic       busy_o
);
	import scg_pkg::*;
	// Sign of the running burst, taken at its strobe
	logic sgn_r;
	always_ff @(posedge clk_sys_i)
	begin
		if (slot_strobe_i)
			sgn_r <= !space_time_tx_diversity_i;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	AST_START: assert property (slot_strobe_i |-> ##2 busy_o)
		else $error("no burst after slot strobe");
	AST_STEP: assert property ((out_valid_o && out_ready_i &&
		chip_idx_o != LAST_CHIP) ##1 out_valid_o |->
		chip_idx_o == $past(chip_idx_o) + 8'h01 || chip_idx_o == 8'h00)
		else $error("chip index skipped");
	AST_HOLD: assert property (out_valid_o && !out_ready_i |=>
		out_valid_o && $stable(chip_idx_o) && $stable(psc_chip_o))
		else $error("word lost in stall");
	AST_PSC: assert property (out_valid_o |-> psc_chip_o ==
		(PSC_SEED[chip_idx_o[3:0]] ^ PSC_SEED[chip_idx_o[7:4]] ^ sgn_r))
		else $error("primary chip wrong");
	AST_SLOT: assert property (out_valid_o |-> slot_idx_o <= LAST_SLOT)
		else $error("slot index out of range");
	AST_SLOT_HOLD: assert property (out_valid_o && chip_idx_o != 8'h00
		|-> $stable(slot_idx_o))
		else $error("slot changed inside burst");
	AST_ANT: assert property (!(ant0_en_o && ant1_en_o))
		else $error("both antennas enabled");
	AST_ANT_IDLE: assert property (!busy_o [*2] |->
		!ant0_en_o && !ant1_en_o)
		else $error("antenna enabled while idle");
endmodule

//--- sim/scg_sink.sv
// Transmit path model that accepts chip words, stalling when slow
`timescale 1ns/1ns
module scg_sink
(
	input  wire logic clk_sys_i,
	input  wire logic slow_i,
	input  wire logic coin_i,
	output logic      ready_o = 1'b1
);
	always @(posedge clk_sys_i)
		ready_o <= !slow_i || coin_i;
endmodule

//--- sim/scg_top_test.sv
// Self-checking bench of the sync channel generator
`timescale 1ns/1ns
bind scg_top scg_properties u_prop (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.slot_strobe_i(slot_strobe_i), .out_ready_i(out_ready_i),
	.space_time_tx_diversity_i(space_time_tx_diversity_i),
	.out_valid_o(out_valid_o), .ant0_en_o(ant0_en_o), .ant1_en_o(ant1_en_o),
	.psc_chip_o(psc_chip_o), .slot_idx_o(slot_idx_o),
	.chip_idx_o(chip_idx_o), .busy_o(busy_o));
module scg_top_test;
	import scg_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        stb = 1'b0;
	logic        frm = 1'b0;
	logic [4:0]  grp = 5'h00;
	logic        stx = 1'b0;
	logic        tsw = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] rnd = 32'h00013D57;
	logic        rdy, vld, a0, a1, pc, sc, bsy, ep, es;
	logic [3:0]  sl, slot, k;
	logic [7:0]  ci, n;
	logic        sgn, ant;
	int          nw, cyc, failures, samples_checked;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		samples_checked++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic burst(input logic f, input logic [4:0] g);
		@(posedge clk_sys_i);
		stb <= 1'b1;
		frm <= f;
		grp <= g;
		stx <= rnd[5];
		tsw <= rnd[6];
		slow <= rnd[7];
		sgn = !rnd[5];
		ant = (rnd[6] && !f) ? !ant : 1'b0;
		slot = (f || slot == LAST_SLOT) ? 4'h0 : slot + 4'h1;
		k = g[3:0] + (slot << g[4]);
		n = 8'h00;
		nw = 0;
		@(posedge clk_sys_i);
		stb <= 1'b0;
		frm <= 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chk("ant1", ant, a1);
		chk("ant0", !ant, a0);
		chk("busy", 8'h01, bsy);
		while (nw < 256)
			@(posedge clk_sys_i);
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("idle_valid", 8'h00, vld);
		chk("idle_busy", 8'h00, bsy);
		chk("idle_ant", 8'h00, {a1, a0});
	endtask
	scg_top u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.slot_strobe_i(stb), .frame_strobe_i(frm), .code_group_i(grp),
		.space_time_tx_diversity_i(stx), .time_switched_tx_diversity_i(tsw),
		.out_ready_i(rdy), .out_valid_o(vld), .ant0_en_o(a0), .ant1_en_o(a1),
		.psc_chip_o(pc), .ssc_chip_o(sc), .slot_idx_o(sl), .chip_idx_o(ci),
		.busy_o(bsy));
	scg_sink u_sink (.clk_sys_i(clk_sys_i), .slow_i(slow), .coin_i(rnd[9]),
		.ready_o(rdy));
	initial
		forever #10 clk_sys_i = !clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		rnd <= lfsr(rnd);
		cyc++;
		if (cyc == 40000)
		begin
			failures++;
			final_report();
		end
	end
	// Falling edge: handshake and word are settled, no race with the flops
	always @(negedge clk_sys_i)
	begin
		if (reset_i === 1'b0 && vld === 1'b1 && rdy === 1'b1)
		begin
			ep = PSC_SEED[n[3:0]] ^ PSC_SEED[n[7:4]] ^ sgn;
			es = ^(k & n[7:4]) ^ PSC_SEED[n[3:0]] ^ sgn;
			chk("chip", n, ci);
			chk("slot", {4'h0, slot}, {4'h0, sl});
			chk("psc", ep, pc);
			chk("ssc", es, sc);
			n = n + 8'h01;
			nw++;
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// Every code group at least once, groups 0 and 1 twice; frame restart after a slot wrap
		for (int i = 0; i < 34; i++)
			burst(i == 0 || i == 17, i[4:0]);
		final_report();
	end
endmodule
